// ---- rss_delay_timer.sv ----
`include "rss_regs.svh"
module rss_delay_timer
   import rss_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 start,
   input  wire logic [`RSS_TMR_W-1:0] load_val,
   output logic                      done
);
   logic [`RSS_TMR_W-1:0] cnt_q;
   logic                  run_q;
   logic                  done_q;
   wire                   last = run_q && (cnt_q <= `RSS_TMR_W'(1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= '0;
         run_q  <= 1'b0;
         done_q <= 1'b0;
      end else if (start) begin
         cnt_q  <= load_val;
         run_q  <= 1'b1;
         done_q <= 1'b0;
      end else if (last) begin
         run_q  <= 1'b0;
         done_q <= 1'b1;
      end else if (run_q) begin
         cnt_q  <= cnt_q - `RSS_TMR_W'(1);
      end
   end

   assign done = done_q;
endmodule

// ---- rss_pkg.sv ----
package rss_pkg;
   typedef enum logic [2:0] {
      RSS_HOLD,
      RSS_POR_DLY,
      RSS_POWER_UP_TIMER_DLY,
      RSS_CLK_CHECK,
      RSS_Q1_WAIT,
      RSS_RUN
   } rss_state_e;
   typedef logic [23:0] rss_pc_t;
endpackage

// ---- rss_regs.svh ----
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

// register byte offsets
`define RSS_CONFIG_OFS        8'h00
`define RSS_CAUSE_OFS         8'h04
`define RSS_OSC_STAT_OFS      8'h08
`define RSS_PC_OFS            8'h0C

// configuration register fields
`define RSS_CFG_FCM_BIT       0
`define RSS_CFG_POWER_UP_TIMER_LSB      1
`define RSS_CFG_FOS_LSB       3
`define RSS_CFG_FPR_LSB       6
`define RSS_CFG_BOREN_BIT     11
`define RSS_CFG_WIDTH         12
`define RSS_CFG_RESET         12'h803

// reset-cause flag positions
`define RSS_F_POR             0
`define RSS_F_BOR             1
`define RSS_F_IDLE            2
`define RSS_F_SLEEP           3
`define RSS_F_WATCHDOG_TIMEOUT_FLAG            4
`define RSS_F_SWR             5
`define RSS_F_PIN_RESET_FLAG            6
`define RSS_F_IOPU            7
`define RSS_F_TRAP            8
`define RSS_CAUSE_WIDTH       9
`define RSS_CAUSE_RESET       9'h000

// oscillator status fields
`define RSS_ST_COSC_LSB       0
`define RSS_ST_CF_BIT         3
`define RSS_ST_LOCK_BIT       5
`define RSS_ST_RUN_BIT        6
`define RSS_ST_INTERNAL_SYSTEM_RESET_BIT     7

// oscillator group codes
`define RSS_OSC_LP            3'h0
`define RSS_OSC_FRC           3'h1
`define RSS_OSC_LOW_POWER_RC_OSC          3'h2
`define RSS_OSC_EXT           3'h3
`define RSS_OSC_PLL           3'h7

// primary selection classes, upper two bits
`define RSS_FPR_EC            2'h0
`define RSS_FPR_EXTERNAL_RC_MODE         2'h1

// vectors
`define RSS_RESET_VECTOR      24'h000000
`define RSS_FAIL_VECTOR       24'h000004
`define RSS_PC_STEP           24'h000002

// timing
`define RSS_CLK_PERIOD_NS     4
`define RSS_POR_DELAY_NS      10000
`define RSS_POR_DELAY_CYC     ((`RSS_POR_DELAY_NS + `RSS_CLK_PERIOD_NS - 1) / `RSS_CLK_PERIOD_NS)
`define RSS_POWER_UP_TIMER_4_MS         4
`define RSS_POWER_UP_TIMER_16_MS        16
`define RSS_POWER_UP_TIMER_64_MS        64
`define RSS_SETTLE_US         100
`define RSS_OST_CYC           1024
`define RSS_TMR_W             25

`endif

// ---- rss_reset_sequencer.sv ----
`include "rss_regs.svh"
module rss_reset_sequencer
   import rss_pkg::*;
#(
   parameter int unsigned POWER_UP_TIMER_4_CYC   = (`RSS_POWER_UP_TIMER_4_MS * 1000000) / `RSS_CLK_PERIOD_NS,
   parameter int unsigned POWER_UP_TIMER_16_CYC  = (`RSS_POWER_UP_TIMER_16_MS * 1000000) / `RSS_CLK_PERIOD_NS,
   parameter int unsigned POWER_UP_TIMER_64_CYC  = (`RSS_POWER_UP_TIMER_64_MS * 1000000) / `RSS_CLK_PERIOD_NS,
   parameter int unsigned SETTLE_CYC   = (`RSS_SETTLE_US * 1000) / `RSS_CLK_PERIOD_NS,
   parameter int unsigned POR_DLY_CYC  = `RSS_POR_DELAY_CYC
)(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        por_detect,
   input  wire logic        brownout_detect,
   input  wire logic        master_clear_pin_n,
   input  wire logic        osc_running,
   input  wire logic        pll_lock,
   input  wire logic        soft_reset_req,
   input  wire logic        watchdog_timeout,
   input  wire logic        trap_lockup,
   input  wire logic        illegal_op,
   input  wire logic        wake_irq,
   input  wire logic        wake_irq_enabled,
   input  wire logic [23:0] wake_irq_vector,
   input  wire logic        cpu_sleep,
   input  wire logic        cpu_idle,
   input  wire logic [23:0] cpu_pc,
   output logic             internal_system_reset,
   output logic             sys_clk_enable,
   output logic [2:0]       current_osc_group,
   output logic             clock_fail_trap,
   output logic             pc_load,
   output logic [23:0]      pc_value
);
   // pin synchronisers
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   wire  [NSYNC-1:0] pin_raw = {pll_lock, osc_running, ~master_clear_pin_n, brownout_detect, por_detect};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   wire por_s   = sync2_q[0];
   wire bor_s   = sync2_q[1];
   wire master_clear_pin_s  = sync2_q[2];
   wire osc_s   = sync2_q[3];
   wire lock_s  = sync2_q[4];

   // registers
   logic [`RSS_CFG_WIDTH-1:0]   cfg_q;
   logic [`RSS_CAUSE_WIDTH-1:0] cause_q;
   logic [`RSS_CAUSE_WIDTH-1:0] cause_d;
   logic [`RSS_CAUSE_WIDTH-1:0] cause_set;
   logic                        cf_q;
   logic [2:0]                  cosc_q;
   rss_state_e                  state_q;
   rss_state_e                  state_d;
   logic [1:0]                  qdiv_q;
   logic                        trap_pend_q;
   logic                        por_prev_q;
   logic                        bor_prev_q;
   logic                        master_clear_pin_prev_q;
   logic                        pc_load_q;
   rss_pc_t                     pc_q;
   logic                        trap_q;

   wire       fcm_en  = cfg_q[`RSS_CFG_FCM_BIT];
   wire [1:0] power_up_timer_sel = cfg_q[`RSS_CFG_POWER_UP_TIMER_LSB +: 2];
   wire [2:0] fos      = cfg_q[`RSS_CFG_FOS_LSB +: 3];
   wire [4:0] fpr      = cfg_q[`RSS_CFG_FPR_LSB +: 5];
   wire       bor_en   = cfg_q[`RSS_CFG_BOREN_BIT];

   // oscillator class decoding
   function automatic logic is_osc_mode(input logic [2:0] grp, input logic [4:0] sel);
      is_osc_mode = (grp == `RSS_OSC_LP) || (grp == `RSS_OSC_PLL) ||
                    ((grp == `RSS_OSC_EXT) && (sel[4:3] != `RSS_FPR_EC) && (sel[4:3] != `RSS_FPR_EXTERNAL_RC_MODE));
   endfunction

   function automatic logic [`RSS_TMR_W-1:0] power_up_timer_cycles(input logic [1:0] s, input logic xtal);
      unique case (s)
         2'h0:    power_up_timer_cycles = xtal ? `RSS_TMR_W'(SETTLE_CYC) : '0;
         2'h1:    power_up_timer_cycles = `RSS_TMR_W'(POWER_UP_TIMER_4_CYC);
         2'h2:    power_up_timer_cycles = `RSS_TMR_W'(POWER_UP_TIMER_16_CYC);
         2'h3:    power_up_timer_cycles = `RSS_TMR_W'(POWER_UP_TIMER_64_CYC);
      endcase
   endfunction

   wire osc_mode  = is_osc_mode(cosc_q, fpr);
   wire pll_used  = (cosc_q == `RSS_OSC_PLL);
   wire internal  = (cosc_q == `RSS_OSC_FRC) || (cosc_q == `RSS_OSC_LOW_POWER_RC_OSC);

   // reset events
   wire bor_evt   = bor_en && bor_s;
   wire por_rise  = por_s && !por_prev_q;
   wire bor_rise  = bor_evt && !bor_prev_q;
   wire master_clear_pin_rise = master_clear_pin_s && !master_clear_pin_prev_q;
   wire hold_lvl  = por_s || bor_evt || master_clear_pin_s;
   wire running   = (state_q == RSS_RUN);
   // a wake never competes with a pin reset that is already holding the core
   wire wake_ok   = running && !hold_lvl && cpu_sleep;
   wire sw_evt    = running && soft_reset_req;
   wire wdt_rst   = running && watchdog_timeout && !cpu_sleep;
   wire wdt_wake  = wake_ok && watchdog_timeout;
   wire trap_evt  = running && trap_lockup;
   wire iop_evt   = running && illegal_op;
   wire irq_wake  = wake_ok && wake_irq && !watchdog_timeout;
   wire rst_evt   = hold_lvl || sw_evt || wdt_rst || trap_evt || iop_evt;
   wire pwr_evt   = por_s || bor_evt;

   always_comb begin
      cause_set = '0;
      cause_set[`RSS_F_POR]   = por_rise;
      cause_set[`RSS_F_BOR]   = por_rise || bor_rise;
      cause_set[`RSS_F_PIN_RESET_FLAG]  = master_clear_pin_rise;
      cause_set[`RSS_F_SLEEP] = (master_clear_pin_rise && cpu_sleep) || wdt_wake || irq_wake;
      cause_set[`RSS_F_IDLE]  = master_clear_pin_rise && cpu_idle && !cpu_sleep;
      cause_set[`RSS_F_SWR]   = sw_evt;
      cause_set[`RSS_F_WATCHDOG_TIMEOUT_FLAG]  = wdt_rst || wdt_wake;
      cause_set[`RSS_F_TRAP]  = trap_evt;
      cause_set[`RSS_F_IOPU]  = iop_evt;
   end

   // stage timer and start-up timer
   wire stage_done;
   wire ost_done;
   wire leave_hold = (state_q == RSS_HOLD) && !hold_lvl;
   wire rapid      = !fcm_en && (power_up_timer_sel == 2'h0) && !osc_mode;
   wire [`RSS_TMR_W-1:0] power_up_timer_load = power_up_timer_cycles(power_up_timer_sel, osc_mode);
   wire stage_start = (leave_hold && !rapid) || ((state_q == RSS_POR_DLY) && stage_done);
   wire [`RSS_TMR_W-1:0] stage_load = (state_q == RSS_HOLD) ? `RSS_TMR_W'(POR_DLY_CYC) : power_up_timer_load;
   wire ost_start  = leave_hold && osc_mode;

   rss_delay_timer u_stage_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (stage_start),
      .load_val (stage_load),
      .done     (stage_done)
   );

   rss_delay_timer u_ost_tmr (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (ost_start),
      .load_val (`RSS_TMR_W'(`RSS_OST_CYC)),
      .done     (ost_done)
   );

   // clock readiness
   wire ost_ok  = !osc_mode || ost_done;
   wire lock_ok = !pll_used || lock_s;
   wire clk_ok  = internal || (osc_s && ost_ok && lock_ok);
   wire q1      = (qdiv_q == 2'h0);

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         RSS_HOLD:      if (!hold_lvl) state_d = rapid ? RSS_CLK_CHECK : RSS_POR_DLY;
         RSS_POR_DLY:   if (stage_done) state_d = RSS_POWER_UP_TIMER_DLY;
         RSS_POWER_UP_TIMER_DLY:  if (stage_done) state_d = RSS_CLK_CHECK;
         RSS_CLK_CHECK: if (clk_ok || fcm_en) state_d = RSS_Q1_WAIT;
         RSS_Q1_WAIT:   if (q1) state_d = RSS_RUN;
         RSS_RUN:       state_d = RSS_RUN;
      endcase
      if (rst_evt) state_d = RSS_HOLD;
   end

   wire fail_now = (state_q == RSS_CLK_CHECK) && !clk_ok && fcm_en && !rst_evt;
   wire release_now = (state_q == RSS_Q1_WAIT) && q1 && !rst_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= RSS_HOLD;
         qdiv_q  <= 2'h0;
      end else begin
         state_q <= state_d;
         qdiv_q  <= qdiv_q + 2'h1;
      end
   end

   // edge detectors on the synchronised reset sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_prev_q  <= 1'b0;
         bor_prev_q  <= 1'b0;
         master_clear_pin_prev_q <= 1'b0;
      end else begin
         por_prev_q  <= por_s;
         bor_prev_q  <= bor_evt;
         master_clear_pin_prev_q <= master_clear_pin_s;
      end
   end

   // clock source and trap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cosc_q      <= `RSS_OSC_FRC;
         trap_pend_q <= 1'b0;
         trap_q      <= 1'b0;
      end else begin
         trap_q <= fail_now;
         if (pwr_evt) begin
            cosc_q      <= fos;
            trap_pend_q <= 1'b0;
         end else if (fail_now) begin
            cosc_q      <= `RSS_OSC_FRC;
            trap_pend_q <= 1'b1;
         end else if (release_now || rst_evt) begin
            trap_pend_q <= 1'b0;
         end
      end
   end

   // program counter load
   wire     pc_load_d = release_now || wdt_wake || irq_wake;
   rss_pc_t pc_step;
   rss_pc_t pc_wake;
   rss_pc_t pc_rst;
   rss_pc_t pc_d;
   assign pc_step = cpu_pc + `RSS_PC_STEP;
   assign pc_wake = (irq_wake && wake_irq_enabled) ? wake_irq_vector : pc_step;
   assign pc_rst  = trap_pend_q ? `RSS_FAIL_VECTOR : `RSS_RESET_VECTOR;
   assign pc_d    = release_now ? pc_rst : pc_wake;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load_q <= 1'b0;
         pc_q      <= `RSS_RESET_VECTOR;
      end else begin
         pc_load_q <= pc_load_d;
         if (pc_load_d) begin
            pc_q <= pc_d;
         end
      end
   end

   // apb slave, zero wait states
   wire acc      = psel && penable;
   wire wr       = acc && pwrite;
   wire hit_cfg  = (paddr == `RSS_CONFIG_OFS);
   wire hit_cau  = (paddr == `RSS_CAUSE_OFS);
   wire hit_st   = (paddr == `RSS_OSC_STAT_OFS);
   wire hit_pc   = (paddr == `RSS_PC_OFS);
   wire hit_any  = hit_cfg || hit_cau || hit_st || hit_pc;
   wire [31:0] stat_word = {24'h0, !running, osc_s, lock_s, 1'b0, cf_q, cosc_q};
   // software clears the fail flag by writing one; a new failure in that cycle wins
   wire        cf_clr    = wr && hit_st && pwdata[`RSS_ST_CF_BIT];

   assign cause_d = ((wr && hit_cau) ? pwdata[`RSS_CAUSE_WIDTH-1:0] : cause_q) | cause_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q   <= `RSS_CFG_RESET;
         cause_q <= `RSS_CAUSE_RESET;
         cf_q    <= 1'b0;
      end else begin
         if (wr && hit_cfg) begin
            cfg_q <= pwdata[`RSS_CFG_WIDTH-1:0];
         end
         cause_q <= cause_d;
         cf_q    <= fail_now || (cf_q && !cf_clr);
      end
   end

   always_comb begin
      prdata = 32'h0;
      if (acc && !pwrite) begin
         if (hit_cfg) prdata = {20'h0, cfg_q};
         if (hit_cau) prdata = {23'h0, cause_q};
         if (hit_st)  prdata = stat_word;
         if (hit_pc)  prdata = {8'h0, pc_q};
      end
   end

   assign pready  = 1'b1;
   assign pslverr = acc && !hit_any;

   // outputs
   assign internal_system_reset = !running;
   assign sys_clk_enable        = clk_ok && (state_q != RSS_HOLD);
   assign current_osc_group     = cosc_q;
   assign clock_fail_trap       = trap_q;
   assign pc_load               = pc_load_q;
   assign pc_value              = pc_q;
endmodule

// ---- rss_reset_sequencer_assertions.sv ----
module rss_reset_sequencer_assertions
   import rss_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        soft_reset_req,
   input wire logic        watchdog_timeout,
   input wire logic        wake_irq,
   input wire logic        wake_irq_enabled,
   input wire logic [23:0] wake_irq_vector,
   input wire logic        cpu_sleep,
   input wire logic [23:0] cpu_pc,
   input wire logic        internal_system_reset,
   input wire logic [2:0]  current_osc_group,
   input wire logic        clock_fail_trap,
   input wire logic        pc_load,
   input wire logic [23:0] pc_value
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_apb_zero_wait: assert property (psel && penable |-> pready)
      else $error("pready low in access phase");
   a_unmapped_err: assert property (psel && penable && paddr > 8'h0C |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_release_load: assert property ($fell(internal_system_reset) |-> pc_load)
      else $error("no pc load after release");
   a_frozen_pc: assert property (internal_system_reset |-> !pc_load)
      else $error("pc loaded while held in reset");
   a_trap_vector: assert property (clock_fail_trap |-> ##[1:8] (pc_load && pc_value == 24'h000004))
      else $error("clock fail trap not vectored to 4");
   a_trap_group: assert property (clock_fail_trap |=> current_osc_group == 3'h1 && !clock_fail_trap)
      else $error("clock fail did not select fast rc");
   a_load_single: assert property (pc_load |=> !pc_load)
      else $error("pc load longer than one cycle");
   a_soft_reset: assert property (soft_reset_req && !internal_system_reset && !cpu_sleep
      |-> ##[1:4] internal_system_reset)
      else $error("soft reset not taken");
   a_wdt_wake: assert property (watchdog_timeout && cpu_sleep && !internal_system_reset
      |=> pc_load && pc_value == $past(cpu_pc) + 24'h2 && !internal_system_reset)
      else $error("watchdog wake pc wrong");
   a_irq_wake: assert property (wake_irq && wake_irq_enabled && cpu_sleep && !internal_system_reset
      |=> pc_load && pc_value == $past(wake_irq_vector))
      else $error("enabled wake vector wrong");
   c_trap: cover property (clock_fail_trap);
   c_release: cover property ($fell(internal_system_reset));
   c_wake: cover property (pc_load && pc_value != 24'h0 && pc_value != 24'h4);
endmodule

bind rss_reset_sequencer rss_reset_sequencer_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .soft_reset_req(soft_reset_req), .watchdog_timeout(watchdog_timeout), .wake_irq(wake_irq),
   .wake_irq_enabled(wake_irq_enabled), .wake_irq_vector(wake_irq_vector), .cpu_sleep(cpu_sleep),
   .cpu_pc(cpu_pc), .internal_system_reset(internal_system_reset), .current_osc_group(current_osc_group),
   .clock_fail_trap(clock_fail_trap), .pc_load(pc_load), .pc_value(pc_value));

// ---- rss_reset_sequencer_tb.sv ----
module rss_reset_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdv, rv;
   logic        por_detect = 1, brownout_detect = 0, master_clear_pin_n = 1, osc_running = 0, pll_lock = 0;
   logic        soft_reset_req = 0, watchdog_timeout = 0, trap_lockup = 0, illegal_op = 0, wake_irq = 0;
   logic        wake_irq_enabled = 0, cpu_sleep = 0, cpu_idle = 0;
   logic        internal_system_reset, sys_clk_enable, clock_fail_trap, pc_load;
   logic [23:0] wake_irq_vector = 0, cpu_pc = 0, pc_value;
   logic [2:0]  current_osc_group;
   logic [23:0] exp_q[$];
   logic [8:0]  ctab[4] = '{9'h020, 9'h010, 9'h100, 9'h080};
   logic [31:0] rs = 32'h12;
   int          n_fail = 0, checks_done = 0, dly;

   always #2 pclk = ~pclk;

   rss_reset_sequencer #(.POWER_UP_TIMER_4_CYC(20), .POWER_UP_TIMER_16_CYC(40), .POWER_UP_TIMER_64_CYC(80), .SETTLE_CYC(10), .POR_DLY_CYC(30))
   dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_detect(por_detect),
      .brownout_detect(brownout_detect), .master_clear_pin_n(master_clear_pin_n), .osc_running(osc_running),
      .pll_lock(pll_lock), .soft_reset_req(soft_reset_req), .watchdog_timeout(watchdog_timeout),
      .trap_lockup(trap_lockup), .illegal_op(illegal_op), .wake_irq(wake_irq),
      .wake_irq_enabled(wake_irq_enabled), .wake_irq_vector(wake_irq_vector), .cpu_sleep(cpu_sleep),
      .cpu_idle(cpu_idle), .cpu_pc(cpu_pc), .internal_system_reset(internal_system_reset),
      .sys_clk_enable(sys_clk_enable), .current_osc_group(current_osc_group),
      .clock_fail_trap(clock_fail_trap), .pc_load(pc_load), .pc_value(pc_value));

   function logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction

   task test_done();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (e !== s) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task tmo(input int i, input int lim);
      if (i >= lim) begin
         chk("timeout", 0, 1);
         test_done();
      end
   endtask

   // apb master: setup, access, hold until pready sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      tmo(i, 20);
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("prdata", e, rdv);
   endtask

   // raise one event source; pins held long enough to pass the synchroniser
   task fire(input int k);
      @(posedge pclk);
      soft_reset_req     <= (k == 0);
      watchdog_timeout   <= (k == 1);
      trap_lockup        <= (k == 2);
      illegal_op         <= (k == 3);
      brownout_detect    <= (k == 4);
      master_clear_pin_n <= (k != 5);
      wake_irq           <= (k >= 6);
      if (k == 4 || k == 5) repeat (8) @(posedge pclk);
      @(posedge pclk);
      {soft_reset_req, watchdog_timeout, trap_lockup, illegal_op, brownout_detect, wake_irq} <= 6'h00;
      master_clear_pin_n <= 1'b1;
   endtask

   task settle();
      int i;
      dly = 0;
      for (i = 0; i < 5000 && exp_q.size() != 0; i++) begin
         @(posedge pclk);
         if (internal_system_reset === 1'b1) dly++;
      end
      tmo(i, 5000);
   endtask

   task run_ev(input int k, input logic keep, input logic [8:0] cause, input logic [23:0] pc);
      if (!keep) wr(8'h04, 32'h0);
      exp_q.push_back(pc);
      fire(k);
      settle();
      rd(8'h04, {23'h0, cause});
      $display("test event %0d done", k);
   endtask

   // scoreboard: every pc load takes the oldest expected vector
   always @(posedge pclk) begin
      if (pc_load === 1'b1) begin
         if (exp_q.size() == 0) chk("pc_load", 0, 1);
         else chk("pc_value", {8'h0, exp_q.pop_front()}, {8'h0, pc_value});
      end
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h00, 32'h803);
      rd(8'h10, 32'h0);
      exp_q.push_back(24'h000004);
      por_detect <= 1'b0;
      settle();
      chk("sys_clk_enable", 1, sys_clk_enable);
      rd(8'h04, 32'h003);
      rd(8'h08, 32'h009);
      wr(8'h08, 32'h8);
      rd(8'h08, 32'h001);
      wr(8'h04, 32'h155);
      rd(8'h04, 32'h155);
      $display("test power-on trap done");
      wr(8'h00, 32'h808);
      run_ev(0, 0, 9'h020, 24'h0);
      chk("rapid_exit", 1, dly < 20);
      for (int k = 1; k < 4; k++) run_ev(k, 0, ctab[k], 24'h0);
      cpu_sleep <= 1'b1;
      run_ev(4, 0, 9'h002, 24'h0);
      run_ev(5, 0, 9'h048, 24'h0);
      cpu_sleep <= 1'b0;
      cpu_idle <= 1'b1;
      run_ev(5, 0, 9'h044, 24'h0);
      cpu_idle <= 1'b0;
      run_ev(5, 0, 9'h040, 24'h0);
      run_ev(0, 1, 9'h060, 24'h0);
      wr(8'h00, 32'h80E);
      run_ev(4, 0, 9'h002, 24'h0);
      chk("delay", 1, dly >= 110 && dly <= 140);
      cpu_sleep <= 1'b1;
      rv = rnd();
      cpu_pc <= rv[23:0];
      run_ev(1, 0, 9'h018, rv[23:0] + 24'h2);
      run_ev(6, 0, 9'h008, cpu_pc + 24'h2);
      rv = rnd();
      wake_irq_vector <= rv[23:0];
      wake_irq_enabled <= 1'b1;
      run_ev(6, 0, 9'h008, rv[23:0]);
      cpu_sleep <= 1'b0;
      wr(8'h00, 32'hC38);
      wr(8'h04, 32'h0);
      exp_q.push_back(24'h0);
      fire(4);
      repeat (300) @(posedge pclk);
      chk("frozen", 1, internal_system_reset);
      chk("sys_clk_enable", 0, sys_clk_enable);
      osc_running <= 1'b1;
      repeat (200) @(posedge pclk);
      chk("sys_clk_enable", 0, sys_clk_enable);
      repeat (1300) @(posedge pclk);
      chk("frozen", 1, internal_system_reset);
      chk("sys_clk_enable", 0, sys_clk_enable);
      pll_lock <= 1'b1;
      settle();
      chk("sys_clk_enable", 1, sys_clk_enable);
      rd(8'h08, 32'h067);
      rd(8'h04, 32'h002);
      $display("test frozen clock done");
      test_done();
   end
endmodule
